/* File: design/acc_map.vh */
// register map, field positions and timing counts of the conversion controller
// Operation
// - sample-mode bit: 1 pulse, 0 extended
// - extended mode, async clock: result may be wrong
// - overlapping trigger in multi modes halts conversions
// - triggers from software start or timer
// - overflow flag unreliable for overlap detection
// - recovery: clear enable/power, set power, enable
// - clock switch hang: code 11, gate-off, divide 3/5/7
// - hang cleared only by reset
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

`define ACC_ADR_CTRL     4'h0
`define ACC_ADR_STATUS   4'h4
`define ACC_ADR_RESULT   4'h8
`define ACC_ADR_TIMER    4'hC

`define ACC_CTRL_ENABLE  0
`define ACC_CTRL_POWER   1
`define ACC_CTRL_START   2
`define ACC_CTRL_PULSE   3
`define ACC_CTRL_TIMER   4
`define ACC_CTRL_SEQ_LO  5
`define ACC_CTRL_SEQ_HI  6
`define ACC_CTRL_CSEL_LO 8
`define ACC_CTRL_CSEL_HI 9
`define ACC_CTRL_DIV_LO  10
`define ACC_CTRL_DIV_HI  12
`define ACC_CTRL_GATEOFF 13

`define ACC_STAT_BUSY    0
`define ACC_STAT_HALTED  1
`define ACC_STAT_HANG    2
`define ACC_STAT_OVF     3
`define ACC_STAT_SUSPECT 4

`define ACC_SEQ_SINGLE   2'h0
`define ACC_SEQ_SEQ      2'h1
`define ACC_SEQ_RPT_ONE  2'h2
`define ACC_SEQ_RPT_SEQ  2'h3

`define ACC_CSEL_SUBSYS  2'h3
`define ACC_CSEL_SYNC    2'h3
`define ACC_DIV_3        3'h2
`define ACC_DIV_5        3'h4
`define ACC_DIV_7        3'h6

`define ACC_RST_CTRL     14'h0000
`define ACC_RST_TIMER    16'h0000
`define ACC_SAMPLE_TICKS 8'h04
`define ACC_CONV_TICKS   8'h0D

`endif

/* File: design/acc_clkdiv.v */
// conversion clock divider: one-cycle tick every (div+1) system clocks
`timescale 1ns/1ps
`default_nettype none
module acc_clkdiv #(
  parameter W = 3
) (
  input  wire         i_mclk,
  input  wire         i_sys_rst,
  input  wire         i_run,
  input  wire [W-1:0] i_div,
  output reg          o_tick
);
  reg [W-1:0] cnt;

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt    <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt    <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (cnt >= i_div) begin
      cnt    <= {W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + {{(W-1){1'b0}}, 1'b1};
      o_tick <= 1'b0;
    end
  end
endmodule // acc_clkdiv
`default_nettype wire

/* File: design/acc_ctrl.v */
// conversion control with wishbone register slave, sequencing, halt and hang
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.vh"
module acc_ctrl #(
  parameter DW    = 12,
  parameter NCH   = 4,
  parameter CHW   = 2
) (
  input  wire          i_mclk,
  input  wire          i_sys_rst,
  input  wire          i_wb_cyc,
  input  wire          i_wb_stb,
  input  wire          i_wb_we,
  input  wire [3:0]    i_wb_adr,
  input  wire [3:0]    i_wb_sel,
  input  wire [31:0]   i_wb_dat,
  output reg  [31:0]   o_wb_dat,
  output reg           o_wb_ack,
  input  wire          i_sample_hold_input,
  input  wire [DW-1:0] i_sample_data,
  output reg           o_converter_busy_flag,
  output reg           o_conversion_done,
  output reg  [DW-1:0] o_result,
  output reg  [CHW-1:0] o_result_channel,
  output reg           o_conv_hang
);
  localparam ST_IDLE    = 2'd0;
  localparam ST_SAMPLE  = 2'd1;
  localparam ST_CONVERT = 2'd2;

  reg           conversion_enable;
  reg           converter_power_on;
  reg           sample_pulse_mode_select;
  reg           sample_timer_source_select;
  reg [1:0]     conversion_sequence_select;
  reg [1:0]     conversion_clock_select;
  reg [2:0]     conversion_clock_divider;
  reg           subsystem_clock_gate_off;
  reg [15:0]    timer_period;
  reg [15:0]    timer_cnt;
  reg [1:0]     state;
  reg [7:0]     phase_cnt;
  reg [CHW-1:0] channel;
  reg           halted;
  reg           conversion_time_overflow_flag;
  reg           result_suspect;
  reg           shi_s1;
  reg           shi_s2;
  reg           shi_s3;
  reg           shi_stable;
  wire          conv_tick;

  // bus decode
  wire req      = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wr       = req & i_wb_we;
  wire wr_ctrl0 = wr & (i_wb_adr == `ACC_ADR_CTRL) & i_wb_sel[0];
  wire wr_ctrl1 = wr & (i_wb_adr == `ACC_ADR_CTRL) & i_wb_sel[1];
  wire wr_stat  = wr & (i_wb_adr == `ACC_ADR_STATUS) & i_wb_sel[0];
  wire wr_timer = wr & (i_wb_adr == `ACC_ADR_TIMER);

  // new control values as seen after a write
  wire       new_power = wr_ctrl0 ? i_wb_dat[`ACC_CTRL_POWER] : converter_power_on;
  wire [1:0] new_csel  = wr_ctrl1 ? i_wb_dat[`ACC_CTRL_CSEL_HI:`ACC_CTRL_CSEL_LO]
                                  : conversion_clock_select;

  wire active = conversion_enable & converter_power_on & ~halted & ~o_conv_hang;
  wire sw_trig  = wr_ctrl0 & i_wb_dat[`ACC_CTRL_START] & ~sample_timer_source_select;
  wire tmr_trig = sample_timer_source_select & conv_tick & (timer_cnt >= timer_period);
  wire trig     = active & (sw_trig | tmr_trig);
  wire last_ch  = (channel == NCH[CHW-1:0] - {{(CHW-1){1'b0}}, 1'b1});
  wire multi    = (conversion_sequence_select != `ACC_SEQ_SINGLE);

  // clock-switch hazard: leaving the subsystem clock while gated, odd divide
  wire odd_div  = (conversion_clock_divider == `ACC_DIV_3) |
                  (conversion_clock_divider == `ACC_DIV_5) |
                  (conversion_clock_divider == `ACC_DIV_7);
  wire hang_hit = wr_ctrl1 & (conversion_clock_select == `ACC_CSEL_SUBSYS) &
                  (new_csel != `ACC_CSEL_SUBSYS) & subsystem_clock_gate_off & odd_div;

  acc_clkdiv #(.W(3)) u_div (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_run     (converter_power_on & ~o_conv_hang),
    .i_div     (conversion_clock_divider),
    .o_tick    (conv_tick)
  );

  // sample/hold input is asynchronous: three stages, accept when 2 and 3 agree
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shi_s1     <= 1'b0;
      shi_s2     <= 1'b0;
      shi_s3     <= 1'b0;
      shi_stable <= 1'b0;
    end else begin
      shi_s1 <= i_sample_hold_input;
      shi_s2 <= shi_s1;
      shi_s3 <= shi_s2;
      if (shi_s2 == shi_s3) begin
        shi_stable <= shi_s3;
      end
    end
  end

  // control registers
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      conversion_enable          <= 1'b0;
      converter_power_on         <= 1'b0;
      sample_pulse_mode_select   <= 1'b0;
      sample_timer_source_select <= 1'b0;
      conversion_sequence_select <= `ACC_SEQ_SINGLE;
      conversion_clock_select    <= 2'h0;
      conversion_clock_divider   <= 3'h0;
      subsystem_clock_gate_off   <= 1'b0;
      timer_period               <= `ACC_RST_TIMER;
    end else begin
      if (wr_ctrl0) begin
        converter_power_on         <= i_wb_dat[`ACC_CTRL_POWER];
        // enable only sticks while power is on, so the same write must also set the power bit
        conversion_enable          <= i_wb_dat[`ACC_CTRL_ENABLE] & new_power;
        sample_pulse_mode_select   <= i_wb_dat[`ACC_CTRL_PULSE];
        sample_timer_source_select <= i_wb_dat[`ACC_CTRL_TIMER];
        conversion_sequence_select <= i_wb_dat[`ACC_CTRL_SEQ_HI:`ACC_CTRL_SEQ_LO];
      end
      if (wr_ctrl1) begin
        conversion_clock_select  <= new_csel;
        conversion_clock_divider <= i_wb_dat[`ACC_CTRL_DIV_HI:`ACC_CTRL_DIV_LO];
        subsystem_clock_gate_off <= i_wb_dat[`ACC_CTRL_GATEOFF];
      end
      if (wr_timer) begin
        if (i_wb_sel[0]) timer_period[7:0]  <= i_wb_dat[7:0];
        if (i_wb_sel[1]) timer_period[15:8] <= i_wb_dat[15:8];
      end
    end
  end

  // hang is sticky: nothing but the system reset releases it
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_conv_hang <= 1'b0;
    end else if (hang_hit) begin
      o_conv_hang <= 1'b1;
    end
  end

  // trigger timer runs on conversion ticks
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      timer_cnt <= 16'h0000;
    end else if (!(sample_timer_source_select & active)) begin
      timer_cnt <= 16'h0000;
    end else if (conv_tick) begin
      timer_cnt <= (timer_cnt >= timer_period) ? 16'h0000 : timer_cnt + 16'h0001;
    end
  end

  // conversion sequencer
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state                         <= ST_IDLE;
      phase_cnt                     <= 8'h00;
      channel                       <= {CHW{1'b0}};
      halted                        <= 1'b0;
      conversion_time_overflow_flag <= 1'b0;
      result_suspect                <= 1'b0;
      o_converter_busy_flag         <= 1'b0;
      o_conversion_done             <= 1'b0;
      o_result                      <= {DW{1'b0}};
      o_result_channel              <= {CHW{1'b0}};
    end else begin
      o_conversion_done <= 1'b0;
      if (halted & ~conversion_enable & ~converter_power_on) begin
        halted <= 1'b0;
      end
      if (wr_stat & i_wb_dat[`ACC_STAT_OVF]) begin
        conversion_time_overflow_flag <= 1'b0;
      end
      if (!converter_power_on || o_conv_hang) begin
        state                 <= ST_IDLE;
        o_converter_busy_flag <= 1'b0;
      end else if (trig && state != ST_IDLE) begin
        if (multi) begin
          // overlap in a multi-conversion mode stops everything until recovery
          halted                <= 1'b1;
          state                 <= ST_IDLE;
          o_converter_busy_flag <= 1'b0;
        end else begin
          // overlap only flags in single mode, so the flag misses halts
          conversion_time_overflow_flag <= 1'b1;
        end
      end else if (trig) begin
        state                 <= ST_SAMPLE;
        phase_cnt             <= 8'h00;
        channel               <= {CHW{1'b0}};
        o_converter_busy_flag <= 1'b1;
      end else if (conv_tick) begin
        case (state)
          ST_SAMPLE: begin
            if (sample_pulse_mode_select) begin
              if (phase_cnt >= `ACC_SAMPLE_TICKS - 8'h01) begin
                state     <= ST_CONVERT;
                phase_cnt <= 8'h00;
              end else begin
                phase_cnt <= phase_cnt + 8'h01;
              end
            end else if (!shi_stable) begin
              // extended mode: sampling lasts as long as the hold input is high
              state     <= ST_CONVERT;
              phase_cnt <= 8'h00;
            end
          end
          ST_CONVERT: begin
            if (phase_cnt >= `ACC_CONV_TICKS - 8'h01) begin
              phase_cnt         <= 8'h00;
              o_result          <= i_sample_data;
              o_result_channel  <= channel;
              o_conversion_done <= 1'b1;
              // async clock against the hold input can corrupt extended results
              result_suspect    <= ~sample_pulse_mode_select &
                                   (conversion_clock_select != `ACC_CSEL_SYNC);
              if (!conversion_enable ||
                  conversion_sequence_select == `ACC_SEQ_SINGLE ||
                  (conversion_sequence_select == `ACC_SEQ_SEQ && last_ch)) begin
                state                 <= ST_IDLE;
                o_converter_busy_flag <= 1'b0;
              end else begin
                state <= ST_SAMPLE;
                if (conversion_sequence_select != `ACC_SEQ_RPT_ONE) begin
                  channel <= last_ch ? {CHW{1'b0}} : channel + {{(CHW-1){1'b0}}, 1'b1};
                end
              end
            end else begin
              phase_cnt <= phase_cnt + 8'h01;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // wishbone answer: one cycle after the request, unmapped reads return zero
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= 32'h00000000;
      if (req && !i_wb_we) begin
        case (i_wb_adr)
          `ACC_ADR_CTRL: begin
            o_wb_dat[`ACC_CTRL_ENABLE]  <= conversion_enable;
            o_wb_dat[`ACC_CTRL_POWER]   <= converter_power_on;
            o_wb_dat[`ACC_CTRL_PULSE]   <= sample_pulse_mode_select;
            o_wb_dat[`ACC_CTRL_TIMER]   <= sample_timer_source_select;
            o_wb_dat[`ACC_CTRL_SEQ_HI:`ACC_CTRL_SEQ_LO]   <= conversion_sequence_select;
            o_wb_dat[`ACC_CTRL_CSEL_HI:`ACC_CTRL_CSEL_LO] <= conversion_clock_select;
            o_wb_dat[`ACC_CTRL_DIV_HI:`ACC_CTRL_DIV_LO]   <= conversion_clock_divider;
            o_wb_dat[`ACC_CTRL_GATEOFF] <= subsystem_clock_gate_off;
          end
          `ACC_ADR_STATUS: begin
            o_wb_dat[`ACC_STAT_BUSY]    <= o_converter_busy_flag;
            o_wb_dat[`ACC_STAT_HALTED]  <= halted;
            o_wb_dat[`ACC_STAT_HANG]    <= o_conv_hang;
            o_wb_dat[`ACC_STAT_OVF]     <= conversion_time_overflow_flag;
            o_wb_dat[`ACC_STAT_SUSPECT] <= result_suspect;
          end
          `ACC_ADR_RESULT: begin
            o_wb_dat[DW-1:0]     <= o_result;
            o_wb_dat[16+CHW-1:16] <= o_result_channel;
          end
          `ACC_ADR_TIMER: begin
            o_wb_dat[15:0] <= timer_period;
          end
          default: begin
            o_wb_dat <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule // acc_ctrl
`default_nettype wire

/* File: tb/acc_ctrl_props.sv */
// assertion checker for the conversion controller ports
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_props #(
  parameter DW  = 12,
  parameter NCH = 4,
  parameter CHW = 2
) (
  input wire logic           i_mclk,
  input wire logic           i_sys_rst,
  input wire logic           i_wb_cyc,
  input wire logic           i_wb_stb,
  input wire logic           i_wb_we,
  input wire logic [3:0]     i_wb_adr,
  input wire logic [3:0]     i_wb_sel,
  input wire logic [31:0]    i_wb_dat,
  input wire logic [31:0]    o_wb_dat,
  input wire logic           o_wb_ack,
  input wire logic           i_sample_hold_input,
  input wire logic [DW-1:0]  i_sample_data,
  input wire logic           o_converter_busy_flag,
  input wire logic           o_conversion_done,
  input wire logic [DW-1:0]  o_result,
  input wire logic [CHW-1:0] o_result_channel,
  input wire logic           o_conv_hang
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire ctl = req && i_wb_we && i_wb_adr == 4'h0;
  // control write with a clock select other than the subsystem clock code 11
  wire away_wr = ctl && i_wb_sel[1] && i_wb_dat[9:8] != 2'h3;
  sequence s_req;
    req;
  endsequence
  // single-mode manual start on an idle converter
  sequence s_start;
    ctl && i_wb_sel[0] && i_wb_dat[2:0] == 3'h7 && i_wb_dat[6:4] == 3'h0
      && !o_converter_busy_flag && !o_conv_hang;
  endsequence
  a_ack_follows: assert property (s_req |=> o_wb_ack)
    else $error("ack missing after request");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_rdat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data not zero while idle");
  a_start_busy: assert property (s_start |=> o_converter_busy_flag[*8])
    else $error("busy not held after start");
  a_result_done: assert property ($changed(o_result) |-> o_conversion_done)
    else $error("result changed without done");
  a_done_pulse: assert property (o_conversion_done |=> !o_conversion_done)
    else $error("done longer than one cycle");
  a_hang_sticky: assert property (o_conv_hang |=> o_conv_hang)
    else $error("hang cleared without reset");
  a_hang_cause: assert property ($rose(o_conv_hang) |-> $past(away_wr) || $past(away_wr, 2))
    else $error("hang without clock switch");
  a_hang_quiet: assert property (o_conv_hang ##1 o_conv_hang |-> !o_conversion_done)
    else $error("conversion finished while hung");
endmodule // acc_ctrl_props
bind acc_ctrl acc_ctrl_props #(.DW(DW), .NCH(NCH), .CHW(CHW)) u_props (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_sample_hold_input(i_sample_hold_input),
  .i_sample_data(i_sample_data), .o_converter_busy_flag(o_converter_busy_flag),
  .o_conversion_done(o_conversion_done), .o_result(o_result),
  .o_result_channel(o_result_channel), .o_conv_hang(o_conv_hang));
`default_nettype wire

/* File: tb/acc_ctrl_tb.sv */
// self-checking bench for the conversion controller
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.vh"
module acc_ctrl_tb;
  logic        i_mclk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_wb_cyc = 1'b0;
  logic        i_wb_stb = 1'b0;
  logic        i_wb_we = 1'b0;
  logic [3:0]  i_wb_adr = 4'h0;
  logic [3:0]  i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0;
  logic        i_sample_hold_input = 1'b1;
  logic [11:0] i_sample_data = 12'hA5C;
  wire  [31:0] o_wb_dat;
  wire         o_wb_ack;
  wire         o_converter_busy_flag;
  wire         o_conversion_done;
  wire  [11:0] o_result;
  wire  [1:0]  o_result_channel;
  wire         o_conv_hang;
  logic [31:0] rdat;
  logic        seen;
  int          cnt;
  int          checks = 0;
  int          fail_count = 0;
  typedef struct packed {logic w; logic [3:0] a; logic [31:0] d; logic [3:0] s;
                         logic [31:0] e;} acc_row_t;
  acc_row_t rows [0:7] = '{
    '{1'b0, `ACC_ADR_CTRL, 32'h0, 4'hF, 32'h0}, '{1'b0, `ACC_ADR_STATUS, 32'h0, 4'hF, 32'h0},
    '{1'b0, `ACC_ADR_TIMER, 32'h0, 4'hF, 32'h0}, '{1'b1, `ACC_ADR_TIMER, 32'hABCD, 4'hF, 32'h0},
    '{1'b1, `ACC_ADR_TIMER, 32'hFF0012, 4'h1, 32'h0}, '{1'b1, 4'h2, 32'hFFFFFFFF, 4'hF, 32'h0},
    '{1'b0, `ACC_ADR_TIMER, 32'h0, 4'hF, 32'hAB12}, '{1'b0, 4'h2, 32'h0, 4'hF, 32'h0}};
  acc_ctrl #(.DW(12), .NCH(4), .CHW(2)) uut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_sample_hold_input(i_sample_hold_input),
    .i_sample_data(i_sample_data), .o_converter_busy_flag(o_converter_busy_flag),
    .o_conversion_done(o_conversion_done), .o_result(o_result),
    .o_result_channel(o_result_channel), .o_conv_hang(o_conv_hang));
  always #5 i_mclk = ~i_mclk;
  task automatic summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic quit;
    fail_count++;
    $display("ERROR wait bound used up");
    summarize();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // classic cycle: request held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= s;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    if (o_wb_ack !== 1'b1)
      quit();
    rdat = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  // software side: no new start until status shows the converter idle
  task automatic poll_idle;
    int k;
    k = 0;
    rdat = 32'h1;
    while (rdat[`ACC_STAT_BUSY] !== 1'b0 && k < 20) begin
      wb(1'b0, `ACC_ADR_STATUS, 32'h0, 4'hF);
      k++;
    end
    if (rdat[`ACC_STAT_BUSY] !== 1'b0)
      quit();
  endtask
  task automatic wait_done(input int lim, input logic must);
    seen = 1'b0;
    cnt = 0;
    while (!seen && cnt < lim) begin
      @(negedge i_mclk);
      cnt++;
      seen = (o_conversion_done === 1'b1);
    end
    if (must && !seen)
      quit();
  endtask
  task automatic reset_dut;
    @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    repeat (10) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
  endtask
  initial begin
    reset_dut();
    foreach (rows[k]) begin
      wb(rows[k].w, rows[k].a, rows[k].d, rows[k].s);
      if (!rows[k].w)
        chk("register read", rows[k].e, rdat);
    end
    wb(1'b1, `ACC_ADR_CTRL, 32'h0B, 4'h1);
    poll_idle();
    wb(1'b1, `ACC_ADR_CTRL, 32'h0F, 4'h1);
    wait_done(60, 1'b1);
    chk("pulse length", `ACC_SAMPLE_TICKS + `ACC_CONV_TICKS, cnt);
    chk("result", 32'hA5C, o_result);
    wb(1'b0, `ACC_ADR_STATUS, 32'h0, 4'hF);
    chk("status after pulse", 32'h0, rdat[4:0]);
    // overlap on purpose: start again without polling busy
    wb(1'b1, `ACC_ADR_CTRL, 32'h0F, 4'h1);
    wb(1'b1, `ACC_ADR_CTRL, 32'h0F, 4'h1);
    wait_done(60, 1'b1);
    wb(1'b0, `ACC_ADR_STATUS, 32'h0, 4'hF);
    chk("single overlap", 32'h8, rdat[3:0]);
    wb(1'b1, `ACC_ADR_STATUS, 32'h8, 4'h1);
    wb(1'b0, `ACC_ADR_STATUS, 32'h0, 4'hF);
    chk("flag cleared", 32'h0, rdat[3:0]);
    poll_idle();
    wb(1'b1, `ACC_ADR_CTRL, 32'h07, 4'h1);
    repeat (40) @(negedge i_mclk);
    chk("extended waits", 32'h1, o_converter_busy_flag);
    @(posedge i_mclk);
    i_sample_hold_input <= 1'b0;
    wait_done(40, 1'b1);
    wb(1'b0, `ACC_ADR_STATUS, 32'h0, 4'hF);
    chk("suspect result", 32'h10, rdat[4:0]);
    wb(1'b1, `ACC_ADR_CTRL, 32'h2B, 4'h1);
    wb(1'b1, `ACC_ADR_CTRL, 32'h2F, 4'h1);
    wb(1'b1, `ACC_ADR_CTRL, 32'h2F, 4'h1);
    wb(1'b0, `ACC_ADR_STATUS, 32'h0, 4'hF);
    chk("halted", 32'h2, rdat[3:0]);
    wb(1'b1, `ACC_ADR_CTRL, 32'h2F, 4'h1);
    wait_done(80, 1'b0);
    chk("no work when halted", 32'h0, {seen, o_converter_busy_flag});
    wb(1'b1, `ACC_ADR_CTRL, 32'h20, 4'h1);
    wb(1'b1, `ACC_ADR_CTRL, 32'h22, 4'h1);
    wb(1'b1, `ACC_ADR_CTRL, 32'h23, 4'h1);
    wb(1'b1, `ACC_ADR_CTRL, 32'h2F, 4'h1);
    repeat (4) wait_done(60, 1'b1);
    chk("last channel", 32'h3, o_result_channel);
    @(negedge i_mclk);
    chk("idle after sequence", 32'h0, o_converter_busy_flag);
    // repeat single channel keeps channel 0 and halts on an overlapping start
    wb(1'b1, `ACC_ADR_CTRL, 32'h4F, 4'h1);
    repeat (2) wait_done(60, 1'b1);
    chk("repeat one channel", 32'h0, o_result_channel);
    wb(1'b1, `ACC_ADR_CTRL, 32'h4F, 4'h1);
    wb(1'b0, `ACC_ADR_STATUS, 32'h0, 4'hF);
    chk("repeat one halted", 32'h2, rdat[3:0]);
    // recovery into repeat sequence, which wraps and ends when enable drops
    wb(1'b1, `ACC_ADR_CTRL, 32'h60, 4'h1);
    wb(1'b1, `ACC_ADR_CTRL, 32'h62, 4'h1);
    wb(1'b1, `ACC_ADR_CTRL, 32'h63, 4'h1);
    wb(1'b1, `ACC_ADR_CTRL, 32'h6F, 4'h1);
    repeat (4) wait_done(60, 1'b1);
    chk("repeat sequence last", 32'h3, o_result_channel);
    wait_done(60, 1'b1);
    chk("repeat sequence wrap", 32'h0, o_result_channel);
    wb(1'b1, `ACC_ADR_CTRL, 32'h62, 4'h1);
    wait_done(60, 1'b1);
    @(negedge i_mclk);
    chk("enable cleared stops", 32'h0, o_converter_busy_flag);
    // period above sample plus convert ticks
    wb(1'b1, `ACC_ADR_CTRL, 32'h0B, 4'h1);
    wb(1'b1, `ACC_ADR_TIMER, 32'h1E, 4'h3);
    wb(1'b1, `ACC_ADR_CTRL, 32'h1B, 4'h1);
    repeat (2) wait_done(100, 1'b1);
    wb(1'b0, `ACC_ADR_STATUS, 32'h0, 4'hF);
    chk("timer no overlap", 32'h0, rdat[3:0]);
    reset_dut();
    wb(1'b1, `ACC_ADR_CTRL, 32'h2B00, 4'h2);
    wb(1'b1, `ACC_ADR_CTRL, 32'h2800, 4'h2);
    wb(1'b1, `ACC_ADR_CTRL, 32'h0F, 4'h1);
    wait_done(40, 1'b0);
    chk("hung converter idle", 32'h1, {seen, o_converter_busy_flag, o_conv_hang});
    wb(1'b0, `ACC_ADR_STATUS, 32'h0, 4'hF);
    chk("hang status", 32'h4, rdat[2:0]);
    reset_dut();
    @(negedge i_mclk);
    chk("hang after reset", 32'h0, o_conv_hang);
    wb(1'b1, `ACC_ADR_CTRL, 32'h0B00, 4'h2);
    wb(1'b1, `ACC_ADR_CTRL, 32'h0800, 4'h2);
    @(negedge i_mclk);
    chk("gate on switch", 32'h0, o_conv_hang);
    for (int d = 0; d < 8; d++) begin
      reset_dut();
      wb(1'b1, `ACC_ADR_CTRL, 32'h2300 | (d << 10), 4'h2);
      wb(1'b1, `ACC_ADR_CTRL, 32'h2000 | (d << 10), 4'h2);
      @(negedge i_mclk);
      chk("divider hang", d == 2 || d == 4 || d == 6, o_conv_hang);
    end
    summarize();
  end
endmodule // acc_ctrl_tb
`default_nettype wire
